// *** inc/cdctl_consts.svh ***
// Purpose: Offsets, field positions and reset values of the clock control
// Assumes: 32-bit AXI4-Lite register words, byte addresses
`ifndef CDCTL_CONSTS_SVH
`define CDCTL_CONSTS_SVH

`define CDCTL_ADDR_W 8
`define CDCTL_OFS_CTRL 8'h00
`define CDCTL_OFS_MAIN 8'h04
`define CDCTL_OFS_CHAN 8'h08
`define CDCTL_OFS_LOGIC 8'h0c
`define CDCTL_OFS_TREF 8'h10
`define CDCTL_OFS_DELAY 8'h14
`define CDCTL_OFS_TEMP 8'h18
`define CDCTL_OFS_STAT 8'h1c

`define CDCTL_CTRL_RESET 0
`define CDCTL_CTRL_DIVRST 1
`define CDCTL_MAIN_SEL_LSB 0
`define CDCTL_MAIN_DIV_LSB 2
`define CDCTL_MAIN_MUL_LSB 5
`define CDCTL_CHAN_PATH_LSB 0
`define CDCTL_CHAN_BUF_LSB 4
`define CDCTL_CHAN_PWR_LSB 8
`define CDCTL_LOGIC_PRE_LSB 0
`define CDCTL_LOGIC_DIV_LSB 2
`define CDCTL_TREF_EN 0
`define CDCTL_TREF_GEN 1
`define CDCTL_TREF_PRE_LSB 2
`define CDCTL_TREF_DIV_LSB 4
`define CDCTL_TREF_DLY_LSB 16

`define CDCTL_RST_MAIN 32'h0000_0000
`define CDCTL_RST_CHAN 32'h000f_ffff
`define CDCTL_RST_LOGIC 32'h0000_0004
`define CDCTL_RST_TREF 32'h0000_0020
`define CDCTL_RST_DELAY 32'h0000_0000

`define CDCTL_RESP_OKAY 2'b00
`define CDCTL_RESP_SLVERR 2'b10
`define CDCTL_POR_WAIT_US 100

`endif

// *** inc/cdctl_pkg.sv ***
// Purpose: Types of the clock control
// Assumes: Nothing
// Notes: Path selector codes
package cdctl_pkg;
  typedef enum logic [1:0] {
    CDCTL_PATH_BYPASS = 2'h0,
    CDCTL_PATH_DIVIDE = 2'h1,
    CDCTL_PATH_MULT = 2'h2
  } cdctl_path_t;
endpackage

// *** design/cdctl_top.sv ***
// Purpose: Clock distribution control with AXI4-Lite registers
// Assumes: aclk stands for the input clock; one aclk cycle per input cycle
// Notes: Wave outputs model divider phases on aclk
`timescale 1ns/1ps
`default_nettype none
`include "cdctl_consts.svh"

module cdctl_divider #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic clr,
  input wire logic [W-1:0] period,
  output logic wave
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb begin
    if (cnt + W'(1) >= period) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  // High for floor(period/2) cycles: 50% even, 33/40/43% for 3/5/7
  always_ff @(posedge aclk) begin
    if (clr) begin
      cnt <= '0;
      wave <= 1'b0;
    end else begin
      cnt <= next_cnt;
      if (period <= W'(1)) begin
        wave <= ~wave;
      end else begin
        wave <= (next_cnt < (period >> 1));
      end
    end
  end
endmodule // cdctl_divider

module cdctl_top
  import cdctl_pkg::*;
#(
  parameter int NCH = 4,
  parameter int NREF = 5,
  parameter int DLY_STAGES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CDCTL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CDCTL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timing_ref_request_input,
  input wire logic [9:0] temp_code,
  output logic [NCH-1:0] main_clock_out,
  output logic [NCH-1:0] channel_path_power,
  output logic [NCH-1:0] output_buffer_power,
  output logic [3*NCH-1:0] output_power_level,
  output logic [1:0] main_multiply_select,
  output logic multiplier_active,
  output logic logic_clock_output,
  output logic delay_generation_divider,
  output logic [NCH-1:0] timing_ref_out,
  output logic logic_timing_ref_output
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus state
  logic [31:0] ctrl_reg;
  logic [31:0] main_reg;
  logic [31:0] chan_reg;
  logic [31:0] logic_reg;
  logic [31:0] tref_reg;
  logic [31:0] delay_reg;
  logic [9:0] temp_reg;
  logic soft_pulse;
  logic aw_full;
  logic w_full;
  logic [`CDCTL_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wr_word;
  logic [31:0] wr_merged;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    case (aw_addr)
      `CDCTL_OFS_CTRL: wr_word = ctrl_reg;
      `CDCTL_OFS_MAIN: wr_word = main_reg;
      `CDCTL_OFS_CHAN: wr_word = chan_reg;
      `CDCTL_OFS_LOGIC: wr_word = logic_reg;
      `CDCTL_OFS_TREF: wr_word = tref_reg;
      `CDCTL_OFS_DELAY: wr_word = delay_reg;
      default: begin
        wr_word = '0;
        wr_hit = 1'b0;
      end
    endcase
  end

  assign wr_merged = merge(wr_word, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CDCTL_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `CDCTL_RESP_OKAY : `CDCTL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 32'h0;
      main_reg <= `CDCTL_RST_MAIN;
      chan_reg <= `CDCTL_RST_CHAN;
      logic_reg <= `CDCTL_RST_LOGIC;
      tref_reg <= `CDCTL_RST_TREF;
      delay_reg <= `CDCTL_RST_DELAY;
      soft_pulse <= 1'b0;
    end else begin
      soft_pulse <= 1'b0;
      if (do_write && wr_hit) begin
        if (aw_addr == `CDCTL_OFS_CTRL &&
            wr_merged[`CDCTL_CTRL_RESET]) begin
          ctrl_reg <= 32'h1;
          main_reg <= `CDCTL_RST_MAIN;
          chan_reg <= `CDCTL_RST_CHAN;
          logic_reg <= `CDCTL_RST_LOGIC;
          tref_reg <= `CDCTL_RST_TREF;
          delay_reg <= `CDCTL_RST_DELAY;
          soft_pulse <= 1'b1;
        end else begin
          ctrl_reg[`CDCTL_CTRL_RESET] <= 1'b0;
          case (aw_addr)
            `CDCTL_OFS_CTRL: ctrl_reg <= wr_merged
                & 32'h2;
            `CDCTL_OFS_MAIN: main_reg <= wr_merged
                & 32'h7f;
            `CDCTL_OFS_CHAN: chan_reg <= wr_merged
                & 32'hf_ffff;
            `CDCTL_OFS_LOGIC: logic_reg <= wr_merged
                & 32'hfff;
            `CDCTL_OFS_TREF: tref_reg <= wr_merged
                & 32'h3_ffff;
            `CDCTL_OFS_DELAY: delay_reg <= wr_merged
                & 32'h7fff;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_reg <= '0;
    end else begin
      temp_reg <= temp_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CDCTL_OFS_CTRL: rd_word = ctrl_reg;
      `CDCTL_OFS_MAIN: rd_word = main_reg;
      `CDCTL_OFS_CHAN: rd_word = chan_reg;
      `CDCTL_OFS_LOGIC: rd_word = logic_reg;
      `CDCTL_OFS_TREF: rd_word = tref_reg;
      `CDCTL_OFS_DELAY: rd_word = delay_reg;
      `CDCTL_OFS_TEMP: rd_word = {22'h0, temp_reg};
      `CDCTL_OFS_STAT: rd_word = {22'h0, multiplier_active,
          logic_timing_ref_output, timing_ref_out, output_buffer_power};
      default: begin
        rd_word = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CDCTL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `CDCTL_RESP_OKAY : `CDCTL_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider periods
  cdctl_path_t path_sel;
  logic [2:0] div_code;
  logic [3:0] main_period;
  logic [11:0] logic_period;
  logic [13:0] tref_period;
  logic [11:0] tref_div;
  logic [4:0] dgen_period;
  logic div_clr;
  logic main_clr;
  logic main_wave;
  logic logic_wave;
  logic tref_wave;
  logic dgen_wave;

  assign path_sel = cdctl_path_t'(main_reg[`CDCTL_MAIN_SEL_LSB +: 2]);
  assign div_code = main_reg[`CDCTL_MAIN_DIV_LSB +: 3];
  assign div_clr = !aresetn || soft_pulse;
  assign main_clr = div_clr || ctrl_reg[`CDCTL_CTRL_DIVRST];

  // Code 0 is reserved and falls back to bypass
  always_comb begin
    if (path_sel == CDCTL_PATH_DIVIDE && div_code != 3'h0) begin
      main_period = {1'b0, div_code} + 4'h1;
    end else begin
      main_period = 4'h1;
    end
  end

  // Pre-divide codes 0/1/2 give 1/2/4; code 3 is treated as 4
  function automatic logic [2:0] pre_ratio(input logic [1:0] code);
    return (code == 2'h0) ? 3'h1 : ((code == 2'h1) ? 3'h2 : 3'h4);
  endfunction

  always_comb begin
    logic_period = 12'(pre_ratio(logic_reg[`CDCTL_LOGIC_PRE_LSB +: 2])
        * ((logic_reg[`CDCTL_LOGIC_DIV_LSB +: 10] == 10'h0) ? 10'h1
        : logic_reg[`CDCTL_LOGIC_DIV_LSB +: 10]));
    tref_div = tref_reg[`CDCTL_TREF_DIV_LSB +: 12];
    if (tref_div < 12'h2) begin
      tref_div = 12'h2;
    end
    tref_period = 14'(pre_ratio(tref_reg[`CDCTL_TREF_PRE_LSB +: 2])
        * tref_div);
    dgen_period = 5'h2 << tref_reg[`CDCTL_TREF_DLY_LSB +: 2];
  end

  cdctl_divider #(.W(4)) u_main_div (
    .aclk(aclk),
    .clr(main_clr),
    .period(main_period),
    .wave(main_wave)
  );

  cdctl_divider #(.W(12)) u_logic_div (
    .aclk(aclk),
    .clr(div_clr),
    .period(logic_period),
    .wave(logic_wave)
  );

  cdctl_divider #(.W(14)) u_tref_div (
    .aclk(aclk),
    .clr(div_clr),
    .period(tref_period),
    .wave(tref_wave)
  );

  cdctl_divider #(.W(5)) u_dgen_div (
    .aclk(aclk),
    .clr(div_clr),
    .period(dgen_period),
    .wave(dgen_wave)
  );

  ////////////////////////////////////////////////////////////////////////
  // Main outputs and power control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_multiply_select <= 2'h0;
      multiplier_active <= 1'b0;
      logic_clock_output <= 1'b0;
      delay_generation_divider <= 1'b0;
    end else begin
      main_multiply_select <= main_reg[`CDCTL_MAIN_MUL_LSB +: 2];
      multiplier_active <= (path_sel == CDCTL_PATH_MULT);
      logic_clock_output <= logic_wave;
      delay_generation_divider <= dgen_wave;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    logic path_on;
    logic buf_on;
    assign path_on = chan_reg[`CDCTL_CHAN_PATH_LSB + i];
    assign buf_on = path_on && chan_reg[`CDCTL_CHAN_BUF_LSB + i];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        channel_path_power[i] <= 1'b0;
        output_buffer_power[i] <= 1'b0;
        output_power_level[3*i +: 3] <= 3'h0;
        main_clock_out[i] <= 1'b0;
      end else begin
        channel_path_power[i] <= path_on;
        output_buffer_power[i] <= buf_on;
        output_power_level[3*i +: 3] <= buf_on
            ? chan_reg[`CDCTL_CHAN_PWR_LSB + 3*i +: 3] : 3'h0;
        main_clock_out[i] <= buf_on && main_wave;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing reference source and per-output delays
  logic req_sync;
  logic tref_src;
  logic [DLY_STAGES-1:0] dly_line;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_pulse) begin
      req_sync <= 1'b0;
      dly_line <= '0;
    end else begin
      req_sync <= timing_ref_request_input;
      dly_line <= {dly_line[DLY_STAGES-2:0], tref_src};
    end
  end

  assign tref_src = tref_reg[`CDCTL_TREF_EN] &&
      (tref_reg[`CDCTL_TREF_GEN] ? tref_wave : req_sync);

  for (genvar r = 0; r < NREF; r++) begin : g_ref
    logic tap;
    assign tap = dly_line[delay_reg[3*r +: 3]];
    if (r < NCH) begin : g_main_ref
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          timing_ref_out[r] <= 1'b0;
        end else begin
          timing_ref_out[r] <= tap;
        end
      end
    end else begin : g_logic_ref
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          logic_timing_ref_output <= 1'b0;
        end else begin
          logic_timing_ref_output <= tap;
        end
      end
    end
  end

endmodule // cdctl_top
`default_nettype wire

// *** dv/cdctl_far_end.sv ***
// Purpose: Far-side model feeding request and temperature
// Assumes: Request follows the bench command one edge later
// Notes: Temperature code is a fixed level
`timescale 1ns/1ps
`default_nettype none
module cdctl_far_end #(
  parameter logic [9:0] TEMP = 10'h1a5
) (
  input wire logic aclk,
  input wire logic req_go,
  output logic [9:0] temp_code,
  output logic timing_ref_request_input
);
  assign temp_code = TEMP;
  always @(posedge aclk) begin
    timing_ref_request_input <= req_go;
  end
endmodule // cdctl_far_end
`default_nettype wire

// *** dv/cdctl_top_checker.sv ***
// Purpose: Port-level assertions of the clock control
// Assumes: Bound to cdctl_top
// Notes: Reset disables all checks
`timescale 1ns/1ps
`default_nettype none
module cdctl_top_checker #(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] main_clock_out,
  input wire logic [NCH-1:0] channel_path_power,
  input wire logic [NCH-1:0] output_buffer_power,
  input wire logic [3*NCH-1:0] output_power_level,
  input wire logic [NCH-1:0] timing_ref_out,
  input wire logic logic_timing_ref_output
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not on time");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer not on time");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_path_gates: assert property ((output_buffer_power & ~channel_path_power) == '0)
    else $error("buffer on with path off");
  chk_clock_gated: assert property ((main_clock_out & ~output_buffer_power & ~$past(output_buffer_power)) == '0)
    else $error("clock on powered-down output");
  chk_same_freq: assert property (&output_buffer_power && &$past(output_buffer_power) |-> main_clock_out == '0 || &main_clock_out)
    else $error("main outputs differ");
  chk_refs_default: assert property ($rose(aresetn) |-> (timing_ref_out == '0 && !logic_timing_ref_output)[*3])
    else $error("reference out after reset");
  for (genvar i = 0; i < NCH; i++) begin : g_lvl
    chk_level_zero: assert property (!output_buffer_power[i] |-> output_power_level[3*i+:3] == 3'h0)
      else $error("level on powered-down buffer");
  end
endmodule // cdctl_top_checker
`default_nettype wire

// *** dv/cdctl_tb_top.sv ***
// Purpose: Register-level bench of the clock control
// Assumes: Far-end model drives request and temperature
// Notes: Waves measured at falling edges
`timescale 1ns/1ps
`default_nettype none
`include "cdctl_consts.svh"
module cdctl_tb_top;
  import cdctl_pkg::*;
  localparam logic [9:0] TEMP_V = 10'h1a5;
  // aclk cycles per microsecond at 40 MHz
  localparam int CYC_PER_US = 40;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_go = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, multiplier_active, logic_clock_output;
  logic delay_generation_divider, logic_timing_ref_output;
  logic timing_ref_request_input;
  logic [1:0] s_axi_bresp, s_axi_rresp, main_multiply_select;
  logic [31:0] s_axi_rdata;
  logic [9:0] temp_code;
  logic [3:0] main_clock_out, channel_path_power, output_buffer_power;
  logic [3:0] timing_ref_out;
  logic [11:0] output_power_level;
  wire logic [6:0] probe;
  wire logic [4:0] refs;
  int err_total = 0;
  int total_checks = 0;
  int first [5];
  assign probe = {timing_ref_out[0], delay_generation_divider,
                  logic_clock_output, main_clock_out};
  assign refs = {logic_timing_ref_output, timing_ref_out};
  always #12.5 aclk = ~aclk;
  cdctl_far_end #(.TEMP(TEMP_V)) u_far (.aclk, .req_go, .temp_code,
    .timing_ref_request_input);
  cdctl_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timing_ref_request_input,
    .temp_code, .main_clock_out, .channel_path_power, .output_buffer_power,
    .output_power_level, .main_multiply_select, .multiplier_active,
    .logic_clock_output, .delay_generation_divider, .timing_ref_out,
    .logic_timing_ref_output);
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    final_report();
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'b00);
    int n;
    bit aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 1'b1;
      if (s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (++n > 50) hang();
    end
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge aclk);
      if (++n > 50) hang();
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = 2'b00);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (++n > 50) hang();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  task automatic lvl(input int k, input logic v);
    int n;
    n = 0;
    while (probe[k] !== v) begin
      @(negedge aclk);
      if (++n > 5000) hang();
    end
  endtask
  // Skips one full period so a restart after a write is not measured
  task automatic meas(input int k, input int ep, input int eh);
    int hi, per;
    hi = 0;
    per = 0;
    lvl(k, 1'b0);
    lvl(k, 1'b1);
    lvl(k, 1'b0);
    lvl(k, 1'b1);
    while (probe[k] === 1'b1 && per < 5000) begin
      hi++;
      per++;
      @(negedge aclk);
    end
    while (probe[k] !== 1'b1 && per < 5000) begin
      per++;
      @(negedge aclk);
    end
    chk("period", ep, per);
    chk("high", eh, hi);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (`CDCTL_POR_WAIT_US * CYC_PER_US) @(posedge aclk);
    rd(`CDCTL_OFS_CTRL, 32'h0);
    rd(`CDCTL_OFS_MAIN, `CDCTL_RST_MAIN);
    rd(`CDCTL_OFS_CHAN, `CDCTL_RST_CHAN);
    rd(`CDCTL_OFS_LOGIC, `CDCTL_RST_LOGIC);
    rd(`CDCTL_OFS_TREF, `CDCTL_RST_TREF);
    rd(`CDCTL_OFS_DELAY, `CDCTL_RST_DELAY);
    chk("refs", 32'h0, {27'h0, refs});
    chk("bufpwr", 32'hf, {28'h0, output_buffer_power});
    meas(3, 2, 1);
    rd(`CDCTL_OFS_TEMP, {22'h0, TEMP_V});
    wr(`CDCTL_OFS_TEMP, 32'h1, `CDCTL_RESP_SLVERR);
    rd(8'h20, 32'h0, `CDCTL_RESP_SLVERR);
    wr(`CDCTL_OFS_CHAN, 32'h0007_47be);
    repeat (3) @(negedge aclk);
    chk("path", 32'he, {28'h0, channel_path_power});
    chk("buf", 32'ha, {28'h0, output_buffer_power});
    chk("level", 32'h600, {20'h0, output_power_level});
    rd(`CDCTL_OFS_STAT, 32'ha);
    s_axi_wstrb <= 4'h2;
    wr(`CDCTL_OFS_CHAN, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(`CDCTL_OFS_CHAN, 32'h0007_00be);
    for (int c = 0; c < 8; c++) begin
      wr(`CDCTL_OFS_MAIN, 32'h1 | (c << 2));
      meas(1, (c == 0) ? 2 : c + 1, (c == 0) ? 1 : (c + 1) / 2);
    end
    wr(`CDCTL_OFS_CTRL, 32'h2);
    wr(`CDCTL_OFS_CTRL, 32'h0);
    meas(1, 8, 4);
    for (int c = 0; c < 4; c++) begin
      wr(`CDCTL_OFS_MAIN, 32'h2 | (c << 5));
      repeat (3) @(negedge aclk);
      chk("mulsel", c, {30'h0, main_multiply_select});
      chk("mulact", 32'h1, {31'h0, multiplier_active});
    end
    wr(`CDCTL_OFS_LOGIC, 32'h1 | (2 << 2));
    meas(4, 4, 2);
    wr(`CDCTL_OFS_LOGIC, 32'h2 | (4 << 2));
    meas(4, 16, 8);
    wr(`CDCTL_OFS_LOGIC, 1023 << 2);
    meas(4, 1023, 511);
    for (int n = 0; n < 4; n++) begin
      wr(`CDCTL_OFS_TREF, `CDCTL_RST_TREF | (n << 16));
      meas(5, 2 << n, 1 << n);
    end
    wr(`CDCTL_OFS_DELAY, {17'h0, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0});
    wr(`CDCTL_OFS_TREF, `CDCTL_RST_TREF | 32'h1);
    first = '{-1, -1, -1, -1, -1};
    @(posedge aclk);
    req_go <= 1'b1;
    for (int k = 0; k < 30; k++) begin
      @(negedge aclk);
      for (int i = 0; i < 5; i++) begin
        if (refs[i] === 1'b1 && first[i] < 0) first[i] = k;
      end
    end
    for (int i = 1; i < 5; i++) begin
      chk("refdly", i, first[i] - first[0]);
    end
    wr(`CDCTL_OFS_TREF, 32'h3 | (1 << 2) | (3 << 4));
    meas(6, 6, 3);
    wr(`CDCTL_OFS_CTRL, 32'h1);
    wr(`CDCTL_OFS_MAIN, 32'h1 | (3 << 2));
    rd(`CDCTL_OFS_MAIN, 32'hd);
    rd(`CDCTL_OFS_CTRL, 32'h0);
    rd(`CDCTL_OFS_CHAN, `CDCTL_RST_CHAN);
    rd(`CDCTL_OFS_TREF, `CDCTL_RST_TREF);
    chk("refs", 32'h0, {27'h0, refs});
    wr(`CDCTL_OFS_CTRL, 32'h1);
    rd(`CDCTL_OFS_CTRL, 32'h1);
    wr(`CDCTL_OFS_CTRL, 32'h0);
    rd(`CDCTL_OFS_CTRL, 32'h0);
    final_report();
  end
endmodule // cdctl_tb_top
bind cdctl_top cdctl_top_checker #(.NCH(NCH)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .main_clock_out, .channel_path_power, .output_buffer_power,
  .output_power_level, .timing_ref_out, .logic_timing_ref_output);
`default_nettype wire
